// ---- hdl/lcc_pkg.sv ----
package lcc_pkg;
  // Register addresses on the two-bit register port
  localparam logic [1:0] LCC_ADDR_STATUS = 2'h0;
  localparam logic [1:0] LCC_ADDR_CONFIG = 2'h1;
  localparam logic [1:0] LCC_ADDR_DIO = 2'h2;
  localparam logic [1:0] LCC_ADDR_MODE = 2'h3;
  localparam int LCC_DATA_W = 8;
  localparam logic [7:0] LCC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] LCC_READ_ZERO = 8'h00;

  // Synchronised pin vector positions
  localparam int LCC_PIN_W = 5;
  localparam int LCC_PIN_DRV_EN = 0;
  localparam int LCC_PIN_TX_CTRL = 1;
  localparam int LCC_PIN_TX_DATA = 2;
  localparam int LCC_PIN_LINE_HI = 3;
  localparam int LCC_PIN_AUX_HI = 4;
  localparam int LCC_SYNC_DEPTH = 3;

  // Line configuration register, D7 down to D0
  typedef struct packed {
    logic receiverFilterSelect; // D7: 0 = 500kHz, 1 = 1MHz
    logic fastSlewSelect; // D6
    logic openDrainLowSide; // D5: 1 low side, 0 high side
    logic pushPullSelect; // D4
    logic lineDriverEnableBit; // D3
    logic outputLevel; // D2
    logic receiverDisable; // D1
    logic lineSinkEnable; // D0
  } lcc_config_t;

  // Line driver pin drive: level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } lcc_drive_t;

  // Register port request
  typedef struct packed {
    logic write;
    logic read;
    logic [1:0] addr;
    logic [7:0] wdata;
  } lcc_req_t;
endpackage : lcc_pkg

// ---- hdl/lcc_pin_sync.sv ----
`timescale 1ns/10ps
// Three-stage synchroniser; output changes only once stages two and three
// agree, which also rejects a one-cycle glitch.
module lcc_pin_sync
  import lcc_pkg::*;
#(
  parameter int WIDTH = LCC_PIN_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins in, clean levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1; // Read only by stage2
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pinOut;

  // Per-bit agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        next_pinOut[i] = pinOut[i];
        if (stage2[i] == stage3[i]) begin
          next_pinOut[i] = stage3[i];
        end
      end
    end
  endgenerate

  // Shift chain and filtered output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      pinOut <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      pinOut <= next_pinOut;
    end
  end
endmodule : lcc_pin_sync

// ---- hdl/lcc_line_config.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Filter bit selects 500kHz or 1MHz corner
// - One filter bit drives both receivers
// - Fast slew bit raises driver slew rate
// - Open-drain side bit: 1 low, 0 high
// - Push-pull bit makes driver push-pull
// - Driver enabled by bit or pin
// - Line polarity matches software level bit while both transmit pins are high
// - Level bit zero: pins steer driver
// - Receiver disable forces receive output high
// - Sink bit switches line current sink
// - Sink forced off while driver enabled
// - Config register read/write, resets zero
// - Aux flag follows aux input level, aux output is its inverse
// - Inverted line flag tracks line; receive output does unless receiver disabled
// - Level bit acts per driver style
// - Inverted line flag ignores receiver disable
module lcc_line_config
  import lcc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire lcc_req_t regReq,
  output logic [LCC_DATA_W-1:0] regRdata,
  output logic regRvalid,
  // Controller pins
  input wire logic driver_enable_pin,
  input wire logic transmit_control_pin,
  input wire logic transmit_data_pin,
  // Comparator levels from the analog front end
  input wire logic lineHigh,
  input wire logic aux_digital_input,
  // Line driver pin
  output logic lineOut,
  output logic lineOe,
  // Analog trims and sink
  output logic receiver_filter_select,
  output logic fast_slew_select,
  output logic lineSinkOn,
  // Receive side
  output logic rxOut,
  output logic aux_input_out,
  output logic line_level_inverted_flag,
  output logic aux_input_level_flag
);
  lcc_config_t cfg; // Line configuration register
  lcc_config_t next_cfg;
  logic [LCC_DATA_W-1:0] next_regRdata;
  logic next_regRvalid;
  logic [LCC_PIN_W-1:0] pinRaw;
  logic [LCC_PIN_W-1:0] pinSync; // Clean pin levels
  logic driverOn; // Driver enabled by bit or pin
  logic driveLevel; // Wanted line level
  lcc_drive_t drv;

  // Read decode, used for the read data; the valid strobe follows any read
  function automatic logic [LCC_DATA_W-1:0] read_value(
    input logic [1:0] addr,
    input lcc_config_t c
  );
    // Other registers live outside this block and read zero here
    read_value = (addr == LCC_ADDR_CONFIG) ? c : LCC_READ_ZERO;
  endfunction : read_value

  assign pinRaw = {aux_digital_input, lineHigh, transmit_data_pin,
                   transmit_control_pin, driver_enable_pin};

  // Pins come from another domain
  lcc_pin_sync #(
    .WIDTH(LCC_PIN_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(pinRaw),
    .pinOut(pinSync)
  );

  // Register next values
  always_comb begin
    next_cfg = cfg;
    next_regRdata = regRdata;
    next_regRvalid = 1'b0;
    if (regReq.write && regReq.addr == LCC_ADDR_CONFIG) begin
      next_cfg = lcc_config_t'(regReq.wdata);
    end
    if (regReq.read) begin
      next_regRdata = read_value(regReq.addr, cfg);
      next_regRvalid = 1'b1;
    end
  end

  // Register storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= lcc_config_t'(LCC_CONFIG_RESET);
      regRdata <= LCC_READ_ZERO;
      regRvalid <= 1'b0;
    end else begin
      cfg <= next_cfg;
      regRdata <= next_regRdata;
      regRvalid <= next_regRvalid;
    end
  end

  // Driver enable and level; with both pins high the level bit decides,
  // otherwise the pins do, so a set level bit left on holds the level high and blocks the pins
  always_comb begin
    driverOn = cfg.lineDriverEnableBit | pinSync[LCC_PIN_DRV_EN];
    driveLevel = cfg.outputLevel |
      ~(pinSync[LCC_PIN_TX_CTRL] & pinSync[LCC_PIN_TX_DATA]);
    drv.out = driveLevel;
    drv.oe = 1'b0;
    if (!driverOn) begin
      drv.out = 1'b0;
    end else if (cfg.pushPullSelect) begin
      drv.oe = 1'b1;
    end else if (cfg.openDrainLowSide) begin
      drv.out = 1'b0;
      drv.oe = ~driveLevel;
    end else begin
      drv.out = 1'b1;
      drv.oe = driveLevel;
    end
  end

  assign lineOut = drv.out;
  assign lineOe = drv.oe;
  // Same bit trims both filters; no separate aux setting exists
  assign receiver_filter_select = cfg.receiverFilterSelect;
  assign fast_slew_select = cfg.fastSlewSelect;
  // Sink off while driving saves power
  assign lineSinkOn = cfg.lineSinkEnable & ~driverOn;
  assign rxOut = cfg.receiverDisable | ~pinSync[LCC_PIN_LINE_HI];
  assign line_level_inverted_flag = ~pinSync[LCC_PIN_LINE_HI];
  assign aux_input_level_flag = pinSync[LCC_PIN_AUX_HI];
  assign aux_input_out = ~pinSync[LCC_PIN_AUX_HI];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_write_cfg;
    regReq.write && regReq.addr == LCC_ADDR_CONFIG |=>
      cfg == $past(regReq.wdata);
  endproperty
  a_write_cfg: assert property (p_write_cfg)
    else $error("config write not stored");

  property p_read_cfg;
    regReq.read && regReq.addr == LCC_ADDR_CONFIG |=>
      regRvalid && regRdata == $past(cfg);
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("config read wrong");

  property p_enable;
    (cfg.lineDriverEnableBit || pinSync[LCC_PIN_DRV_EN]) == driverOn;
  endproperty
  a_enable: assert property (p_enable)
    else $error("driver enable wrong");

  property p_sink_off;
    driverOn |-> !lineSinkOn;
  endproperty
  a_sink_off: assert property (p_sink_off)
    else $error("sink on while driving");

  property p_sink_on;
    cfg.lineSinkEnable && !driverOn |-> lineSinkOn;
  endproperty
  a_sink_on: assert property (p_sink_on)
    else $error("sink not on");

  property p_rx_dis;
    cfg.receiverDisable |-> rxOut;
  endproperty
  a_rx_dis: assert property (p_rx_dis)
    else $error("receive output not forced high");

  property p_line_level_inverted_flag;
    line_level_inverted_flag == rxOut || cfg.receiverDisable;
  endproperty
  a_line_level_inverted_flag: assert property (p_line_level_inverted_flag)
    else $error("line flag and receive output disagree");

  property p_aux;
    aux_input_level_flag != aux_input_out;
  endproperty
  a_aux: assert property (p_aux)
    else $error("aux flag not inverse of aux output");

  property p_pushpull;
    driverOn && cfg.pushPullSelect && pinSync[LCC_PIN_TX_CTRL] &&
      pinSync[LCC_PIN_TX_DATA] |-> lineOe && lineOut == cfg.outputLevel;
  endproperty
  a_pushpull: assert property (p_pushpull)
    else $error("push-pull level wrong");

  property p_lowside;
    driverOn && !cfg.pushPullSelect && cfg.openDrainLowSide |->
      !lineOut && lineOe == !driveLevel;
  endproperty
  a_lowside: assert property (p_lowside)
    else $error("low-side drive wrong");

  property p_off;
    !driverOn |-> !lineOe;
  endproperty
  a_off: assert property (p_off)
    else $error("driver active while disabled");

  property p_filter;
    receiver_filter_select == cfg.receiverFilterSelect &&
      fast_slew_select == cfg.fastSlewSelect;
  endproperty
  a_filter: assert property (p_filter)
    else $error("trim outputs wrong");

  property p_cv_sw;
    driverOn && !cfg.pushPullSelect && !cfg.openDrainLowSide && lineOe;
  endproperty
  c_sw: cover property (p_cv_sw);

  property p_cv_sink;
    lineSinkOn ##1 !lineSinkOn;
  endproperty
  c_sink: cover property (p_cv_sink);

  property p_cv_rd;
    regRvalid && regRdata != LCC_READ_ZERO;
  endproperty
  c_rd: cover property (p_cv_rd);
endmodule : lcc_line_config

// ---- verification/lcc_host_model.sv ----
`timescale 1ns/10ps
// Host controller: register port and controller pins
module lcc_host_model
  import lcc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output lcc_req_t regReq,
  input wire logic [LCC_DATA_W-1:0] regRdata,
  input wire logic regRvalid,
  // Controller pins
  output logic drvEn,
  output logic txCtrl,
  output logic txData
);
  // Idle bus at time zero
  initial begin
    regReq = '0;
    {drvEn, txCtrl, txData} = 3'h0;
  end

  // One write, held across its taking edge
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regReq = '{1'b1, 1'b0, a, d};
    @(posedge clk);
    // Released bus shows junk, never the old word
    #1 regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  // One read; answer sampled 1 ns after the edge that takes it
  task automatic rd(input logic [1:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1 regReq = '{1'b0, 1'b1, a, 8'h5a};
    @(posedge clk);
    #1 regReq.read = 1'b0;
    d = regRdata;
    v = regRvalid;
  endtask : rd

  // Pins are levels; both transmit pins high hand over to software
  task automatic pins(input logic en, input logic c, input logic q);
    {drvEn, txCtrl, txData} = {en, c, q};
  endtask : pins
endmodule : lcc_host_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
// Self-checking bench for the line channel config block
module tb_top;
  import lcc_pkg::*;
  logic clk, rst_n, lineHigh, auxIn, drvEn, txCtrl, txData;
  lcc_req_t regReq;
  logic [7:0] regRdata, rd, cfg, ex;
  logic regRvalid, rv, lineOut, lineOe, filt, slew, sinkOn;
  logic rxOut, auxOut, lineFlag, auxFlag;
  logic [1:0] a;
  logic [31:0] r;
  logic [31:0] seed = 32'h3c47;
  int err_count = 0;
  int n_checks = 0;

  lcc_line_config u_lcc_line_config (.clk(clk), .rst_n(rst_n),
    .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
    .driver_enable_pin(drvEn), .transmit_control_pin(txCtrl),
    .transmit_data_pin(txData), .lineHigh(lineHigh),
    .aux_digital_input(auxIn), .lineOut(lineOut), .lineOe(lineOe),
    .receiver_filter_select(filt), .fast_slew_select(slew),
    .lineSinkOn(sinkOn), .rxOut(rxOut), .aux_input_out(auxOut),
    .line_level_inverted_flag(lineFlag), .aux_input_level_flag(auxFlag));

  lcc_host_model u_lcc_host_model (.clk(clk), .regReq(regReq),
    .regRdata(regRdata), .regRvalid(regRvalid), .drvEn(drvEn),
    .txCtrl(txCtrl), .txData(txData));

  // Xorshift, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected outputs from config c and pins {aux,line,txd,txc,en}
  function automatic logic [8:0] expo(logic [7:0] c, logic [4:0] p);
    logic on, lvl, o, e;
    on = c[3] | p[0];
    lvl = c[2] | ~(p[1] & p[2]);
    o = c[4] ? lvl : ~c[5];
    e = c[4] | (c[5] ? ~lvl : lvl);
    return {o & on, e & on, c[7], c[6], c[0] & ~on,
      c[1] | ~p[3], ~p[4], ~p[3], p[4]};
  endfunction : expo

  // Compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and stop
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Watchdog, far beyond the few thousand cycles of the run
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    lineHigh = 1'b0;
    auxIn = 1'b0;
    cfg = LCC_CONFIG_RESET;
    repeat (3) @(posedge clk);
    #1;
    // Held in reset: driver off, receive outputs idle high
    chk({lineOut, lineOe, filt, slew, sinkOn, rxOut, auxOut, lineFlag,
      auxFlag}, expo(LCC_CONFIG_RESET, 5'h00));
    rst_n = 1'b1;
    u_lcc_host_model.rd(LCC_ADDR_CONFIG, rd, rv);
    chk({rv, rd}, {1'b1, LCC_CONFIG_RESET});
    for (int i = 0; i < 200; i++) begin
      r = rnd();
      // First passes hit every address, one with all ones
      a = (i < 4) ? i[1:0] : (r[8] ? LCC_ADDR_CONFIG : r[10:9]);
      ex = (i == 1) ? 8'hff : r[7:0];
      u_lcc_host_model.wr(a, ex);
      if (a == LCC_ADDR_CONFIG) begin
        cfg = ex;
      end
      chk({7'h00, filt, slew}, {7'h00, cfg[7:6]});
      // Both transmit pins high more often than not
      u_lcc_host_model.pins(r[11], r[12] | r[13], r[12] | r[14]);
      lineHigh = r[15];
      auxIn = r[16];
      // Synchroniser needs four edges
      repeat (6) @(posedge clk);
      #1;
      chk({lineOut, lineOe, filt, slew, sinkOn, rxOut, auxOut, lineFlag,
        auxFlag}, expo(cfg, {auxIn, lineHigh, txData, txCtrl, drvEn}));
      a = r[18:17];
      u_lcc_host_model.rd(a, rd, rv);
      chk({rv, rd}, {1'b1, (a == LCC_ADDR_CONFIG) ? cfg : 8'h00});
    end
    // Second reset mid-run clears the register
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    u_lcc_host_model.rd(LCC_ADDR_CONFIG, rd, rv);
    chk({rv, rd}, {1'b1, LCC_CONFIG_RESET});
    // Outputs follow the cleared register once the pins resync
    cfg = LCC_CONFIG_RESET;
    repeat (4) @(posedge clk);
    #1;
    chk({lineOut, lineOe, filt, slew, sinkOn, rxOut, auxOut, lineFlag,
      auxFlag}, expo(cfg, {auxIn, lineHigh, txData, txCtrl, drvEn}));
    end_sim();
  end
endmodule : tb_top
